// ===== rtl/ebt_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "ebt_timer_regs.vh"
module ebt_timer #(
  parameter PRESCALE_WIDTH = `EBT_PRESCALE_WIDTH
) (
  // Clock and reset.
  input wire clock,
  input wire rst,
  input wire clockEnable,
  // Register port.
  input wire [2:0] address,
  input wire [7:0] writeData,
  input wire writeStrobe,
  input wire readStrobe,
  output reg [7:0] readData,
  // Processor side.
  input wire globalIrqEnable,
  input wire ackCompareA,
  input wire ackCompareB,
  input wire ackOverflow,
  output wire irqCompareA,
  output wire irqCompareB,
  output wire irqOverflow,
  // Pins.
  input wire externalCountPin,
  output reg waveformOutA,
  output reg waveformOutB,
  output wire waveformEnableA,
  output wire waveformEnableB
);
  reg [7:0] controlA;
  reg [3:0] controlB;
  reg [7:0] counterValue;
  reg [7:0] compareAValue;
  reg [7:0] compareBValue;
  reg [2:0] interruptEnableMask;
  reg [2:0] interruptFlags;
  reg [PRESCALE_WIDTH-1:0] prescaler;
  reg [PRESCALE_WIDTH-1:0] prescalerLast;
  reg pinMeta;
  reg pinSync;
  reg pinLast;
  reg countingDown;
  reg matchBlocked;
  reg [7:0] next_counter;
  reg next_down;
  reg timerTick;
  wire [1:0] compareAOutputMode = controlA[7:6];
  wire [1:0] compareBOutputMode = controlA[5:4];
  wire [1:0] waveformModeLowBits = controlA[1:0];
  wire waveformModeHighBit = controlB[`EBT_BIT_WGM_HIGH];
  wire [2:0] clockSourceSelect = controlB[2:0];
  wire [2:0] waveMode = {waveformModeHighBit, waveformModeLowBits};
  wire pwmMode = waveformModeLowBits[0];
  wire fastPwm = (waveformModeLowBits == 2'h3);
  wire phaseCorrect = (waveformModeLowBits == 2'h1);
  wire topFromA = waveMode[2] | (waveMode == 3'h2);
  wire [7:0] topValue = topFromA ? compareAValue : `EBT_MAX_VALUE;
  wire writeCtlB = writeStrobe & (address == `EBT_ADDR_CONTROL_B);
  wire forceA = writeCtlB & writeData[`EBT_BIT_FORCE_A] & ~pwmMode;
  wire forceB = writeCtlB & writeData[`EBT_BIT_FORCE_B] & ~pwmMode;
  wire writeCounter = writeStrobe & (address == `EBT_ADDR_COUNTER);
  // Matches only count on a timer tick, so a stopped timer never raises repeated flags.
  wire matchA = timerTick & ~matchBlocked & (counterValue == compareAValue);
  wire matchB = timerTick & ~matchBlocked & (counterValue == compareBValue);
  reg overflowEvent;
  // A tap fires when its bit falls, giving a single-cycle enable every 2^(bitIndex+1) cycles.
  function tapFall;
    input [PRESCALE_WIDTH-1:0] now;
    input [PRESCALE_WIDTH-1:0] last;
    input integer bitIndex;
    begin
      tapFall = last[bitIndex] & ~now[bitIndex];
    end
  endfunction
  always @* begin
    case (clockSourceSelect)
      `EBT_CS_STOP: timerTick = 1'b0;
      `EBT_CS_DIV1: timerTick = 1'b1;
      `EBT_CS_DIV8: timerTick = tapFall(prescaler, prescalerLast, 2);
      `EBT_CS_DIV64: timerTick = tapFall(prescaler, prescalerLast, 5);
      `EBT_CS_DIV256: timerTick = tapFall(prescaler, prescalerLast, 7);
      `EBT_CS_DIV1024: timerTick = tapFall(prescaler, prescalerLast, 9);
      // The pin is read regardless of its direction, so software may drive counting.
      `EBT_CS_EXT_FALL: timerTick = pinLast & ~pinSync;
      `EBT_CS_EXT_RISE: timerTick = ~pinLast & pinSync;
      default: timerTick = 1'b0;
    endcase
  end
  always @* begin
    next_counter = counterValue + 8'h01;
    next_down = countingDown;
    overflowEvent = 1'b0;
    if (phaseCorrect) begin
      if (countingDown) begin
        next_counter = counterValue - 8'h01;
        if (counterValue == 8'h01) begin
          next_down = 1'b0;
          overflowEvent = 1'b1;
        end
        if (counterValue == `EBT_BOTTOM_VALUE) begin
          next_counter = 8'h01;
          next_down = 1'b0;
        end
      end else if (counterValue >= topValue) begin
        next_counter = counterValue - 8'h01;
        next_down = 1'b1;
      end
    end else if (counterValue == topValue && (topFromA || fastPwm)) begin
      next_counter = `EBT_BOTTOM_VALUE;
      overflowEvent = fastPwm & topFromA;
    end
    if (counterValue == `EBT_MAX_VALUE && !phaseCorrect && !(fastPwm && topFromA)) begin
      overflowEvent = 1'b1;
    end
    if (!timerTick) begin
      overflowEvent = 1'b0;
    end
  end
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prescaler <= {PRESCALE_WIDTH{1'b0}};
      prescalerLast <= {PRESCALE_WIDTH{1'b0}};
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
      pinLast <= 1'b0;
    end else if (clockEnable) begin
      prescaler <= prescaler + {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};
      prescalerLast <= prescaler;
      pinMeta <= externalCountPin;
      pinSync <= pinMeta;
      pinLast <= pinSync;
    end
  end
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      controlA <= `EBT_RESET_VALUE;
      controlB <= 4'h0;
      counterValue <= `EBT_RESET_VALUE;
      compareAValue <= `EBT_RESET_VALUE;
      compareBValue <= `EBT_RESET_VALUE;
      interruptEnableMask <= 3'h0;
      interruptFlags <= 3'h0;
      countingDown <= 1'b0;
      matchBlocked <= 1'b0;
      waveformOutA <= 1'b0;
      waveformOutB <= 1'b0;
      readData <= `EBT_RESET_VALUE;
    end else if (clockEnable) begin
      if (writeStrobe) begin
        case (address)
          `EBT_ADDR_CONTROL_A: controlA <= writeData & 8'hF3;
          `EBT_ADDR_CONTROL_B: controlB <= writeData[3:0];
          `EBT_ADDR_COMPARE_A: compareAValue <= writeData;
          `EBT_ADDR_COMPARE_B: compareBValue <= writeData;
          `EBT_ADDR_IRQ_MASK: interruptEnableMask <= writeData[2:0];
          default: ;
        endcase
      end
      if (writeCounter) begin
        counterValue <= writeData;
        matchBlocked <= 1'b1;
      end else if (timerTick) begin
        counterValue <= next_counter;
        countingDown <= next_down;
        matchBlocked <= 1'b0;
      end
      // Clears first, then sets, so an event in the clearing cycle survives.
      interruptFlags <= (interruptFlags
        & ~((writeStrobe && address == `EBT_ADDR_IRQ_FLAGS) ? writeData[2:0] : 3'h0)
        & ~{ackCompareB, ackCompareA, ackOverflow})
        | {matchB, matchA, overflowEvent};
      // Forced matches drive only the waveform, never flags or the counter.
      if ((matchA && !pwmMode) || forceA) begin
        case (compareAOutputMode)
          2'h1: waveformOutA <= ~waveformOutA;
          2'h2: waveformOutA <= 1'b0;
          2'h3: waveformOutA <= 1'b1;
          default: ;
        endcase
      end else if (pwmMode && timerTick && compareAOutputMode[1]) begin
        if (matchA) begin
          waveformOutA <= compareAOutputMode[0] ^ (phaseCorrect & countingDown);
        end else if (fastPwm && counterValue == topValue) begin
          waveformOutA <= ~compareAOutputMode[0];
        end
      end
      if ((matchB && !pwmMode) || forceB) begin
        case (compareBOutputMode)
          2'h1: waveformOutB <= ~waveformOutB;
          2'h2: waveformOutB <= 1'b0;
          2'h3: waveformOutB <= 1'b1;
          default: ;
        endcase
      end else if (pwmMode && timerTick && compareBOutputMode[1]) begin
        if (matchB) begin
          waveformOutB <= compareBOutputMode[0] ^ (phaseCorrect & countingDown);
        end else if (fastPwm && counterValue == topValue) begin
          waveformOutB <= ~compareBOutputMode[0];
        end
      end
      readData <= `EBT_RESET_VALUE;
      if (readStrobe) begin
        case (address)
          `EBT_ADDR_CONTROL_A: readData <= controlA;
          `EBT_ADDR_CONTROL_B: readData <= {4'h0, controlB};
          `EBT_ADDR_COUNTER: readData <= counterValue;
          `EBT_ADDR_COMPARE_A: readData <= compareAValue;
          `EBT_ADDR_COMPARE_B: readData <= compareBValue;
          `EBT_ADDR_IRQ_MASK: readData <= {5'h00, interruptEnableMask};
          `EBT_ADDR_IRQ_FLAGS: readData <= {5'h00, interruptFlags};
          default: readData <= `EBT_RESET_VALUE;
        endcase
      end
    end
  end
  assign irqCompareB = globalIrqEnable & interruptEnableMask[`EBT_BIT_CMP_B] & interruptFlags[`EBT_BIT_CMP_B];
  assign irqCompareA = globalIrqEnable & interruptEnableMask[`EBT_BIT_CMP_A] & interruptFlags[`EBT_BIT_CMP_A];
  assign irqOverflow = globalIrqEnable & interruptEnableMask[`EBT_BIT_OVF] & interruptFlags[`EBT_BIT_OVF];
  // The pin is connected whenever its output mode field is nonzero.
  assign waveformEnableA = (compareAOutputMode != 2'h0);
  assign waveformEnableB = (compareBOutputMode != 2'h0);
endmodule // ebt_timer
`default_nettype wire

// ===== rtl/ebt_timer_regs.vh
`ifndef EBT_TIMER_REGS_VH
`define EBT_TIMER_REGS_VH
`define EBT_ADDR_CONTROL_A 3'h0
`define EBT_ADDR_CONTROL_B 3'h1
`define EBT_ADDR_COUNTER 3'h2
`define EBT_ADDR_COMPARE_A 3'h3
`define EBT_ADDR_COMPARE_B 3'h4
`define EBT_ADDR_IRQ_MASK 3'h5
`define EBT_ADDR_IRQ_FLAGS 3'h6
`define EBT_BIT_FORCE_A 7
`define EBT_BIT_FORCE_B 6
`define EBT_BIT_WGM_HIGH 3
`define EBT_BIT_CMP_B 2
`define EBT_BIT_CMP_A 1
`define EBT_BIT_OVF 0
`define EBT_RESET_VALUE 8'h00
`define EBT_MAX_VALUE 8'hFF
`define EBT_BOTTOM_VALUE 8'h00
`define EBT_CS_STOP 3'h0
`define EBT_CS_DIV1 3'h1
`define EBT_CS_DIV8 3'h2
`define EBT_CS_DIV64 3'h3
`define EBT_CS_DIV256 3'h4
`define EBT_CS_DIV1024 3'h5
`define EBT_CS_EXT_FALL 3'h6
`define EBT_CS_EXT_RISE 3'h7
`define EBT_PRESCALE_WIDTH 10
`endif

// ===== tb/ebt_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ebt_timer_properties (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Register port.
  input wire logic [2:0] address,
  input wire logic [7:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  input wire logic [7:0] readData,
  // Processor side.
  input wire logic globalIrqEnable,
  input wire logic ackOverflow,
  input wire logic irqCompareA,
  input wire logic irqCompareB,
  input wire logic irqOverflow
);
  logic [3:0] lastRd;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // A register keeps the read request so no $past of an expression is needed.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) lastRd <= 4'h0;
    else lastRd <= {readStrobe, address};
  end
  sequence cmpWr_s; writeStrobe && address == 3'h3; endsequence
  sequence cmpRd_s; readStrobe && address == 3'h3; endsequence
  property cmpKeep_p;
    logic [7:0] d;
    (cmpWr_s, d = writeData) ##2 cmpRd_s |=> readData == d;
  endproperty
  irq_global_gate_a: assert property ((irqCompareA || irqCompareB || irqOverflow) |-> globalIrqEnable)
    else $error("irq raised without global enable");
  read_idle_zero_a: assert property (!lastRd[3] |-> readData == 8'h00)
    else $error("read data outside answer cycle");
  ctrl_b_zero_a: assert property (lastRd == 4'h9 |-> readData[7:4] == 4'h0)
    else $error("control b high bits not zero");
  mask_high_zero_a: assert property (lastRd == 4'hD |-> readData[7:3] == 5'h00)
    else $error("mask high bits not zero");
  flag_high_zero_a: assert property (lastRd == 4'hE |-> readData[7:3] == 5'h00)
    else $error("flag high bits not zero");
  unmapped_zero_a: assert property (lastRd == 4'hF |-> readData == 8'h00)
    else $error("unmapped read not zero");
  compare_keep_a: assert property (cmpKeep_p)
    else $error("compare a readback wrong");
  ovf_irq_hold_a: assert property ($fell(irqOverflow) && $past(globalIrqEnable) && globalIrqEnable
    |-> $past(ackOverflow) || $past(writeStrobe))
    else $error("overflow irq dropped without clear");
endmodule // ebt_timer_properties
bind ebt_timer ebt_timer_properties i_props (.clock(clock), .rst(rst), .address(address),
  .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
  .globalIrqEnable(globalIrqEnable), .ackOverflow(ackOverflow), .irqCompareA(irqCompareA),
  .irqCompareB(irqCompareB), .irqOverflow(irqOverflow));
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] e;} ebt_row_t;
  logic clock = 1'b0, rst = 1'b1, writeStrobe = 1'b0, readStrobe = 1'b0, gie = 1'b0;
  logic ackA = 1'b0, ackB = 1'b0, ackO = 1'b0, pin = 1'b0;
  logic [2:0] address = 3'h0;
  logic [7:0] writeData = 8'h00, got;
  wire [7:0] readData;
  wire irqA, irqB, irqO, outA, outB, enA, enB;
  int fails = 0, checks_done = 0, i;
  int dvs [5] = '{1, 8, 64, 256, 1024};
  logic [7:0] fm [5] = '{8'h40, 8'h40, 8'hC0, 8'h80, 8'hC3};
  logic fe [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  ebt_row_t rows [11] = '{'{3'h0, 8'hFF, 8'hF3}, '{3'h0, 8'h00, 8'h00}, '{3'h1, 8'hF8, 8'h08},
    '{3'h1, 8'h00, 8'h00}, '{3'h3, 8'hA5, 8'hA5}, '{3'h4, 8'h5A, 8'h5A}, '{3'h5, 8'hFF, 8'h07},
    '{3'h5, 8'h00, 8'h00}, '{3'h6, 8'hFF, 8'h00}, '{3'h7, 8'hFF, 8'h00}, '{3'h2, 8'h3C, 8'h3C}};
  always #2.5 clock = ~clock;
  ebt_timer i_dut (.clock(clock), .rst(rst), .clockEnable(1'b1), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
    .globalIrqEnable(gie), .ackCompareA(ackA), .ackCompareB(ackB), .ackOverflow(ackO),
    .irqCompareA(irqA), .irqCompareB(irqB), .irqOverflow(irqO), .externalCountPin(pin),
    .waveformOutA(outA), .waveformOutB(outB), .waveformEnableA(enA), .waveformEnableB(enB));
  task conclude;
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task rng(input logic [7:0] g, input logic [7:0] lo, input logic [7:0] hi);
    checks_done++;
    if (!(g >= lo && g <= hi) || ^g === 1'bx) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, lo);
    end
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e); rng(g, e, e); endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock) begin address <= a; writeData <= d; writeStrobe <= 1'b1; end
    @(posedge clock) writeStrobe <= 1'b0;
  endtask
  task rd(input logic [2:0] a);
    @(posedge clock) begin address <= a; readStrobe <= 1'b1; end
    @(posedge clock) readStrobe <= 1'b0;
    #1 got = readData;
  endtask
  task rc(input logic [2:0] a, input logic [7:0] e); rd(a); chk(got, e); endtask
  task pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge clock);
      pin <= 1'b1;
      repeat (4) @(posedge clock);
      pin <= 1'b0;
    end
    repeat (6) @(posedge clock);
  endtask
  initial begin #400000; fails++; conclude; end
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 7; i++) rc(i[2:0], 8'h00);
    foreach (rows[k]) begin wr(rows[k].a, rows[k].w); rc(rows[k].a, rows[k].e); end
    // Counter is stopped here, so only the forced strobe can move the outputs.
    for (i = 0; i < 5; i++) begin
      wr(3'h0, fm[i]);
      wr(3'h1, 8'h80);
      repeat (3) @(posedge clock);
      chk({6'h0, outA, enA}, {6'h0, fe[i], 1'b1});
    end
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h10);
    wr(3'h1, 8'h40);
    repeat (3) @(posedge clock);
    chk({6'h0, outB, enB}, 8'h03);
    rc(3'h6, 8'h00);
    wr(3'h5, 8'h07);
    gie <= 1'b1;
    wr(3'h3, 8'h05);
    wr(3'h4, 8'h09);
    wr(3'h2, 8'h00);
    wr(3'h1, 8'h01);
    for (i = 0; i < 400 && irqO !== 1'b1; i++) @(posedge clock);
    if (i == 400) begin fails++; conclude; end
    wr(3'h1, 8'h00);
    rc(3'h6, 8'h07);
    chk({5'h0, irqB, irqA, irqO}, 8'h07);
    wr(3'h6, 8'h02);
    rc(3'h6, 8'h05);
    @(posedge clock) ackB <= 1'b1;
    @(posedge clock) ackB <= 1'b0;
    rc(3'h6, 8'h01);
    wr(3'h5, 8'h06);
    #1 chk({7'h0, irqO}, 8'h00);
    wr(3'h5, 8'h01);
    #1 chk({7'h0, irqO}, 8'h01);
    @(posedge clock) ackO <= 1'b1;
    @(posedge clock) ackO <= 1'b0;
    rc(3'h6, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h1, 8'h01);
    wr(3'h2, 8'h05);
    repeat (10) @(posedge clock);
    wr(3'h1, 8'h00);
    rc(3'h6, 8'h04);
    wr(3'h2, 8'h00);
    wr(3'h1, 8'h07);
    pulses(4);
    rc(3'h2, 8'h04);
    wr(3'h1, 8'h06);
    pulses(3);
    rc(3'h2, 8'h07);
    for (i = 1; i < 6; i++) begin
      wr(3'h1, 8'h00);
      wr(3'h2, 8'h00);
      wr(3'h1, i[7:0]);
      repeat (dvs[i - 1] * 20) @(posedge clock);
      wr(3'h1, 8'h00);
      rd(3'h2);
      rng(got, 8'd19, 8'd22);
    end
    conclude;
  end
endmodule // tb_top
`default_nettype wire
